// ==== pkg/cdr_regs.vh ====
// register addresses, field positions and reset values of the converter
// assumes inclusion by design files only
`ifndef CDR_REGS_VH
`define CDR_REGS_VH

`define CDR_ADDR_NOP      8'h00
`define CDR_ADDR_CODE     8'h01
`define CDR_ADDR_READ     8'h02
`define CDR_ADDR_CONFIG   8'h55
`define CDR_ADDR_RESET    8'h56

`define CDR_RD_STATUS     2'b00
`define CDR_RD_CODE       2'b01
`define CDR_RD_CONFIG     2'b10

`define CDR_CFG_EXT_RES   13
`define CDR_CFG_DRIVE_ON  12
`define CDR_CFG_RATE_HI   11
`define CDR_CFG_RATE_LO   8
`define CDR_CFG_INC_HI    7
`define CDR_CFG_INC_LO    5
`define CDR_CFG_RAMP_ON   4
`define CDR_CFG_CHAIN_ON  3
`define CDR_CFG_RANGE_HI  2
`define CDR_CFG_RANGE_LO  0
`define CDR_CFG_WMASK     16'h3fff

`define CDR_ST_FAULT      2
`define CDR_ST_RAMPING    1
`define CDR_ST_OVERTEMP   0
`define CDR_RESET_BIT     0

`define CDR_RANGE_4_20    3'b101
`define CDR_RANGE_0_20    3'b110
`define CDR_RANGE_0_24    3'b111

`define CDR_CODE_RST      16'h0000
`define CDR_CONFIG_RST    16'h0000
`define CDR_FRAME_BITS    24

`endif

// ==== hw/cdr_sync.v ====
// two-stage synchroniser for a single level from outside the clock domain
// assumes the destination clock is CLK of the enclosing block
`timescale 1ns/1ps
`default_nettype none
module cdr_sync (
   input  wire clk,
   input  wire rst,
   input  wire d,
   input  wire rst_val,
   output reg  q
);
   reg meta;
   always @(posedge clk) begin
      if (rst) begin
         meta <= rst_val;
         q    <= rst_val;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== hw/cdr_top.v ====
// register set and control of a serially programmed current converter
// assumes the serial pins and monitor flags are asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none
`include "cdr_regs.vh"
module cdr_top #(
   parameter RES_BITS = 16
) (
   input  wire        CLK,
   input  wire        RST,
   input  wire        SCLK,
   input  wire        SDIN,
   input  wire        LATCH,
   input  wire        ZERO_IN,
   input  wire        FAULT_MON,
   input  wire        TEMP_MON,
   input  wire        RAMP_BUSY,
   output reg         SDO_O,
   output reg         SDO_OE,
   output reg         ALARM_O,
   output reg         ALARM_OE,
   output reg  [15:0] DAC_CODE,
   output reg         DRIVE_ON,
   output reg         EXT_RES_SEL,
   output reg  [2:0]  RANGE_SEL,
   output reg  [3:0]  RAMP_RATE,
   output reg  [2:0]  RAMP_INC,
   output reg         RAMP_ON,
   output reg         CHAIN_ON,
   output reg         ZEROED
);
   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   wire sclk_s, sdin_s, latch_s, zero_s, fault_s, temp_s, busy_s;
   cdr_sync u_s0 (.clk(CLK), .rst(RST), .d(SCLK), .rst_val(1'b0),
                  .q(sclk_s));
   cdr_sync u_s1 (.clk(CLK), .rst(RST), .d(SDIN), .rst_val(1'b0),
                  .q(sdin_s));
   cdr_sync u_s2 (.clk(CLK), .rst(RST), .d(LATCH), .rst_val(1'b0),
                  .q(latch_s));
   cdr_sync u_s3 (.clk(CLK), .rst(RST), .d(ZERO_IN), .rst_val(1'b0),
                  .q(zero_s));
   cdr_sync u_s4 (.clk(CLK), .rst(RST), .d(FAULT_MON), .rst_val(1'b0),
                  .q(fault_s));
   cdr_sync u_s5 (.clk(CLK), .rst(RST), .d(TEMP_MON), .rst_val(1'b0),
                  .q(temp_s));
   cdr_sync u_s6 (.clk(CLK), .rst(RST), .d(RAMP_BUSY), .rst_val(1'b0),
                  .q(busy_s));

   reg sclk_d, latch_d;
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   wire latch_rise = latch_s & ~latch_d;

   // -----------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------
   function [15:0] mask_code;
      input [15:0] w;
      begin
         mask_code = (RES_BITS == 12) ? {w[15:4], 4'h0} : w;
      end
   endfunction

   function [15:0] range_floor;
      input [2:0] r;
      begin
         range_floor = 16'h0000;
      end
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg [23:0] shift;
   reg [5:0]  nbits;
   reg [15:0] code;
   reg [15:0] saved_code;
   reg [15:0] config_w;
   reg        read_pend;
   reg [1:0]  read_sel;
   reg [23:0] out_shift;
   reg        zero_d;

   wire [7:0]  addr = shift[23:16];
   wire [15:0] data = shift[15:0];
   wire [15:0] status = {13'h0000, fault_s, busy_s, temp_s};

   reg [15:0] rd_word;
   always @* begin
      case (read_sel)
         `CDR_RD_STATUS: rd_word = status;
         `CDR_RD_CODE:   rd_word = code;
         `CDR_RD_CONFIG: rd_word = config_w;
         default:        rd_word = 16'h0000;
      endcase
   end

   // -----------------------------------------------------------------
   // shift, latch and register update
   // -----------------------------------------------------------------
   always @(posedge CLK) begin
      sclk_d  <= RST ? 1'b0 : sclk_s;
      latch_d <= RST ? 1'b0 : latch_s;
      zero_d  <= RST ? 1'b0 : zero_s;
      if (RST) begin
         shift      <= 24'h000000;
         nbits      <= 6'd0;
         code       <= `CDR_CODE_RST;
         saved_code <= `CDR_CODE_RST;
         config_w   <= `CDR_CONFIG_RST;
         read_pend  <= 1'b0;
         read_sel   <= 2'b00;
         out_shift  <= 24'h000000;
         SDO_OE     <= 1'b0;
         ZEROED     <= 1'b0;
      end else begin
         if (sclk_rise) begin
            shift <= {shift[22:0], sdin_s};
            if (nbits != 6'd63)
               nbits <= nbits + 6'd1;
         end
         if (sclk_fall)
            out_shift <= {out_shift[22:0], shift[23]};
         // read word loaded once the new select has settled
         if (read_pend) begin
            out_shift <= {rd_word, 8'h00};
            read_pend <= 1'b0;
         end
         if (zero_s && !zero_d) begin
            saved_code <= code;
            ZEROED     <= 1'b1;
         end
         if (latch_rise) begin
            nbits <= 6'd0;
            if (nbits == 6'd0) begin
               if (!zero_s && ZEROED) begin
                  code   <= saved_code;
                  ZEROED <= 1'b0;
               end
            end else begin
               // output released by any frame but a read request
               SDO_OE <= 1'b0;
               case (addr)
                  `CDR_ADDR_CODE: begin
                     if (!zero_s) begin
                        code   <= mask_code(data);
                        ZEROED <= 1'b0;
                     end
                  end
                  `CDR_ADDR_CONFIG: config_w <= data & `CDR_CFG_WMASK;
                  `CDR_ADDR_READ: begin
                     read_pend <= 1'b1;
                     read_sel  <= data[1:0];
                     SDO_OE    <= 1'b1;
                  end
                  `CDR_ADDR_RESET: begin
                     if (data[`CDR_RESET_BIT]) begin
                        code       <= `CDR_CODE_RST;
                        saved_code <= `CDR_CODE_RST;
                        config_w   <= `CDR_CONFIG_RST;
                        // zeroing pin still high keeps the bottom
                        ZEROED     <= zero_s;
                        SDO_OE     <= 1'b0;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   always @(posedge CLK) begin
      if (RST) begin
         SDO_O       <= 1'b0;
         ALARM_O     <= 1'b0;
         ALARM_OE    <= 1'b0;
         DAC_CODE    <= 16'h0000;
         DRIVE_ON    <= 1'b0;
         EXT_RES_SEL <= 1'b0;
         RANGE_SEL   <= 3'b000;
         RAMP_RATE   <= 4'h0;
         RAMP_INC    <= 3'h0;
         RAMP_ON     <= 1'b0;
         CHAIN_ON    <= 1'b0;
      end else begin
         SDO_O       <= (CHAIN_ON && !SDO_OE) ? shift[23] : out_shift[23];
         ALARM_O     <= 1'b0;
         ALARM_OE    <= fault_s | temp_s;
         DAC_CODE    <= (ZEROED || zero_s) ? range_floor(RANGE_SEL) : code;
         DRIVE_ON    <= config_w[`CDR_CFG_DRIVE_ON];
         EXT_RES_SEL <= config_w[`CDR_CFG_EXT_RES];
         RANGE_SEL   <= config_w[`CDR_CFG_RANGE_HI:`CDR_CFG_RANGE_LO];
         RAMP_RATE   <= config_w[`CDR_CFG_RATE_HI:`CDR_CFG_RATE_LO];
         RAMP_INC    <= config_w[`CDR_CFG_INC_HI:`CDR_CFG_INC_LO];
         RAMP_ON     <= config_w[`CDR_CFG_RAMP_ON];
         CHAIN_ON    <= config_w[`CDR_CFG_CHAIN_ON];
      end
   end
endmodule
`default_nettype wire

// ==== sim/cdr_host.sv ====
// host model: shifts 24-bit frames MSB first and pulses the load strobe
// assumes the block samples the serial pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module cdr_host (
   input  wire logic clk,
   input  wire logic sdo_o,
   output var  logic sclk,
   output var  logic sdin,
   output var  logic latch
);
   logic [15:0] rd;
   initial begin
      sclk = 1'b0;
      sdin = 1'b0;
      latch = 1'b0;
   end
   // n of zero gives a bare strobe
   task automatic xfer(input logic [23:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sdin = w[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         if (i >= n - 16) rd = {rd[14:0], sdo_o};
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      sdin = ~sdin;
      repeat (4) @(negedge clk);
      latch = 1'b1;
      repeat (4) @(negedge clk);
      latch = 1'b0;
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ==== sim/cdr_top_sva.sv ====
// checker for the converter register block, bound to its top module
// assumes CLK and the synchronous reset RST of that module
`timescale 1ns/1ps
`default_nettype none
module cdr_top_sva (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        LATCH,
   input wire logic        ZERO_IN,
   input wire logic        FAULT_MON,
   input wire logic        TEMP_MON,
   input wire logic        ALARM_O,
   input wire logic        ALARM_OE,
   input wire logic [15:0] DAC_CODE,
   input wire logic        DRIVE_ON,
   input wire logic [2:0]  RANGE_SEL,
   input wire logic        ZEROED
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   a_alarm_set: assert property (
      (FAULT_MON || TEMP_MON)[*5] |-> ALARM_OE)
      else $error("alarm not raised on fault");
   a_alarm_idle: assert property (
      (!FAULT_MON && !TEMP_MON)[*5] |-> !ALARM_OE)
      else $error("alarm raised with no fault");
   a_alarm_pulls: assert property (ALARM_OE |-> !ALARM_O)
      else $error("alarm pin driven high");
   a_reset_off: assert property (
      $fell(RST) |-> !DRIVE_ON && DAC_CODE == 16'h0)
      else $error("outputs not cleared by reset");
   a_code_hold: assert property (
      (!LATCH && !ZERO_IN)[*8] |-> $stable(DAC_CODE))
      else $error("code changed without a load");
   a_cfg_hold: assert property (
      (!LATCH)[*8] |-> $stable({DRIVE_ON, RANGE_SEL}))
      else $error("config changed without a load");
   a_zero_set: assert property (ZERO_IN[*5] |-> ZEROED)
      else $error("zeroing not applied");
   a_zero_code: assert property (ZEROED[*2] |-> DAC_CODE == 16'h0)
      else $error("zeroed code not at bottom");
   a_zero_keep: assert property ((ZEROED && !LATCH)[*6] |=> ZEROED)
      else $error("zeroing left without a strobe");
endmodule
bind cdr_top cdr_top_sva u_sva (.CLK(CLK), .RST(RST), .LATCH(LATCH),
   .ZERO_IN(ZERO_IN), .FAULT_MON(FAULT_MON), .TEMP_MON(TEMP_MON),
   .ALARM_O(ALARM_O), .ALARM_OE(ALARM_OE), .DAC_CODE(DAC_CODE),
   .DRIVE_ON(DRIVE_ON), .RANGE_SEL(RANGE_SEL), .ZEROED(ZEROED));
`default_nettype wire

// ==== sim/cdr_top_tb_top.sv ====
// self-checking bench: serial frames from the host model, values compared
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module cdr_top_tb_top;
   logic        clk       = 1'b0;
   logic        rst       = 1'b1;
   logic        zero_in   = 1'b0;
   logic        fault_mon = 1'b0;
   logic        temp_mon  = 1'b0;
   logic        ramp_busy = 1'b0;
   wire         sclk, sdin, latch, sdo_o, sdo_oe, alarm_o, alarm_oe, zeroed;
   wire         drive_on, ext_res, ramp_on, chain_on;
   wire  [15:0] dac_code, dac_code12;
   wire  [2:0]  range_sel, ramp_inc;
   wire  [3:0]  ramp_rate;
   // a released serial output shows the inverse of its last bit
   wire         sdo_line = sdo_oe ? sdo_o : ~sdo_o;
   wire  [15:0] cfg = {2'b00, ext_res, drive_on, ramp_rate, ramp_inc,
                       ramp_on, chain_on, range_sel};
   logic [15:0] v;
   logic [15:0] cfgs [3] = '{16'h1235, 16'h2fce, 16'h10f7};
   integer      err_total = 0, total_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   cdr_host u_host (.clk(clk), .sdo_o(sdo_line), .sclk(sclk), .sdin(sdin),
      .latch(latch));
   cdr_top #(.RES_BITS(16)) u_dut (.CLK(clk), .RST(rst), .SCLK(sclk),
      .SDIN(sdin), .LATCH(latch), .ZERO_IN(zero_in), .FAULT_MON(fault_mon),
      .TEMP_MON(temp_mon), .RAMP_BUSY(ramp_busy), .SDO_O(sdo_o),
      .SDO_OE(sdo_oe), .ALARM_O(alarm_o), .ALARM_OE(alarm_oe),
      .DAC_CODE(dac_code), .DRIVE_ON(drive_on), .EXT_RES_SEL(ext_res),
      .RANGE_SEL(range_sel), .RAMP_RATE(ramp_rate), .RAMP_INC(ramp_inc),
      .RAMP_ON(ramp_on), .CHAIN_ON(chain_on), .ZEROED(zeroed));
   // 12-bit variant on the same pins, only its code is watched
   cdr_top #(.RES_BITS(12)) u_dut12 (.CLK(clk), .RST(rst), .SCLK(sclk),
      .SDIN(sdin), .LATCH(latch), .ZERO_IN(zero_in), .FAULT_MON(fault_mon),
      .TEMP_MON(temp_mon), .RAMP_BUSY(ramp_busy), .SDO_O(), .SDO_OE(),
      .ALARM_O(), .ALARM_OE(), .DAC_CODE(dac_code12), .DRIVE_ON(),
      .EXT_RES_SEL(), .RANGE_SEL(), .RAMP_RATE(), .RAMP_INC(),
      .RAMP_ON(), .CHAIN_ON(), .ZEROED());
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_host.xfer({a, d}, 24);
   endtask
   task automatic rd(input logic [1:0] s);
      wr(8'h02, {14'h0, s});
      chk({15'h0, sdo_oe}, 16'h0001);
      wr(8'h00, 16'h0);
      v = u_host.rd;
      chk({15'h0, sdo_oe}, 16'h0000);
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test;
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk(cfg, 16'h0);
      for (int i = 0; i < 3; i++) begin
         wr(8'h55, cfgs[i]);
         chk(cfg, cfgs[i]);
         rd(2'b10);
         chk(v, cfgs[i]);
      end
      wr(8'h01, 16'habcd);
      chk(dac_code, 16'habcd);
      chk(dac_code12, 16'habc0);
      rd(2'b01);
      chk(v, 16'habcd);
      wr(8'h33, 16'h5555);
      chk(dac_code, 16'habcd);
      fault_mon = 1'b1;
      ramp_busy = 1'b1;
      rd(2'b00);
      chk(v, 16'h0006);
      chk({15'h0, alarm_oe}, 16'h1);
      fault_mon = 1'b0;
      ramp_busy = 1'b0;
      temp_mon = 1'b1;
      rd(2'b00);
      chk(v, 16'h0001);
      chk({15'h0, alarm_o}, 16'h0);
      temp_mon = 1'b0;
      zero_in = 1'b1;
      repeat (8) @(negedge clk);
      chk({15'h0, zeroed}, 16'h1);
      chk({15'h0, alarm_oe}, 16'h0);
      wr(8'h01, 16'h1234);
      chk(dac_code, 16'h0);
      zero_in = 1'b0;
      repeat (8) @(negedge clk);
      chk(dac_code, 16'h0);
      u_host.xfer(24'h0, 0);
      chk(dac_code, 16'habcd);
      wr(8'h56, 16'hfffe);
      chk(dac_code, 16'habcd);
      wr(8'h56, 16'h0001);
      chk(dac_code, 16'h0);
      chk(cfg, 16'h0);
      wr(8'h55, 16'h1235);
      wr(8'h01, 16'h5a5a);
      chk(dac_code, 16'h5a5a);
      // second reset in mid-run clears a driven output
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk(dac_code, 16'h0);
      chk(cfg, 16'h0);
      finish_test;
   end
endmodule
`default_nettype wire
